// ===== verilog/udwsc_host.v
`timescale 1ns/10ps
`include "udwsc_defs.vh"

module udwsc_host (
	// clock and reset
	input  wire                        clock_i,
	input  wire                        arst_n_i,
	// command port
	input  wire                        cmd_valid_i,
	input  wire [`UDWSC_KIND_W-1:0]    cmd_kind_i,
	input  wire [`UDWSC_CODE_W-1:0]    cmd_steps_i,
	input  wire                        resync_i,
	output reg                         cmd_ready_o,
	output reg                         cmd_done_o,
	// tracked wiper code
	output reg  [`UDWSC_CODE_W-1:0]    wiper_code_o,
	// device pins
	output reg                         sel_low_n_o,
	output reg                         sel_hv_o,
	output reg                         step_dir_o
);

	// sequencer states
	localparam [2:0] ST_IDLE  = 3'h0;
	localparam [2:0] ST_SETUP = 3'h1;
	localparam [2:0] ST_SEL   = 3'h2;
	localparam [2:0] ST_LOW   = 3'h3;
	localparam [2:0] ST_HIGH  = 3'h4;
	localparam [2:0] ST_END   = 3'h5;
	localparam [2:0] ST_REL   = 3'h6;

	// last count of a pin phase, cut to the counter width on purpose
	localparam integer            PHASE_LAST_INT = `UDWSC_PHASE_CYC - 1;
	localparam [`UDWSC_CNT_W-1:0] PHASE_LAST     = PHASE_LAST_INT[`UDWSC_CNT_W-1:0];

	reg [2:0]                   state_reg;
	reg [`UDWSC_CNT_W-1:0]      cnt_reg;
	reg [`UDWSC_CODE_W-1:0]     left_reg;
	reg                         inc_reg;
	reg                         hv_reg;
	reg                         end_reg;

	reg [2:0]                   state_next;
	reg [`UDWSC_CNT_W-1:0]      cnt_next;
	reg [`UDWSC_CODE_W-1:0]     left_next;
	reg                         inc_next;
	reg                         hv_next;
	reg                         end_next;
	reg                         ready_next;
	reg                         done_next;
	reg [`UDWSC_CODE_W-1:0]     code_next;
	reg                         sel_low_n_next;
	reg                         sel_hv_next;
	reg                         step_next;

	// decoded command kind
	reg                         take_inc;
	reg                         take_hv;
	reg                         take_end;

	wire                        take       = cmd_valid_i & cmd_ready_o & ~resync_i;
	wire                        phase_done = (cnt_reg == PHASE_LAST);

	// direction, select level and the end step level, held before release unless the step count is zero
	always @* begin
		take_inc = 1'b0;
		take_hv  = 1'b0;
		take_end = 1'b0;
		if (cmd_kind_i == `UDWSC_K_INC) begin
			take_inc = 1'b1;
		end else if (cmd_kind_i == `UDWSC_K_INC_COMP) begin
			take_inc = 1'b1;
			take_end = 1'b0;
		end else if (cmd_kind_i == `UDWSC_K_DEC) begin
			take_inc = 1'b0;
		end else if (cmd_kind_i == `UDWSC_K_DEC_COMP) begin
			take_end = 1'b1;
		end else if (cmd_kind_i == `UDWSC_K_HV_INC1) begin
			take_inc = 1'b1;
			take_hv  = 1'b1;
			take_end = 1'b1;
		end else if (cmd_kind_i == `UDWSC_K_HV_INC2) begin
			take_inc = 1'b1;
			take_hv  = 1'b1;
		end else if (cmd_kind_i == `UDWSC_K_HV_DEC1) begin
			take_hv  = 1'b1;
		end else begin
			take_hv  = 1'b1;
			take_end = 1'b1;
		end
	end

	always @* begin
		state_next     = state_reg;
		cnt_next       = phase_done ? 8'h00 : cnt_reg + 8'h01;
		left_next      = left_reg;
		inc_next       = inc_reg;
		hv_next        = hv_reg;
		end_next       = end_reg;
		ready_next     = cmd_ready_o;
		done_next      = 1'b0;
		code_next      = wiper_code_o;
		sel_low_n_next = sel_low_n_o;
		sel_hv_next    = sel_hv_o;
		step_next      = step_dir_o;
		case (state_reg)
			ST_IDLE: begin
				cnt_next   = 8'h00;
				ready_next = ~resync_i & ~take;
				if (resync_i) begin
					// device reloads mid-scale after supply recovery
					code_next = `UDWSC_CODE_POR;
				end
				if (take) begin
					left_next  = cmd_steps_i;
					inc_next   = take_inc;
					hv_next    = take_hv;
					end_next   = take_end;
					// direction set while select is still idle
					step_next  = take_inc;
					state_next = ST_SETUP;
				end
			end
			ST_SETUP: begin
				if (phase_done) begin
					if (hv_reg) begin
						sel_hv_next = 1'b1;
					end else begin
						sel_low_n_next = 1'b0;
					end
					state_next = ST_SEL;
				end
			end
			ST_SEL: begin
				if (phase_done) begin
					if (left_reg == 6'h00) begin
						state_next = ST_END;
					end else begin
						step_next  = 1'b0;
						state_next = ST_LOW;
					end
				end
			end
			ST_LOW: begin
				if (phase_done) begin
					step_next = 1'b1;
					left_next = left_reg - 6'h01;
					// mirror the device's saturating counter
					if (inc_reg && wiper_code_o != `UDWSC_CODE_MAX) begin
						code_next = wiper_code_o + 6'h01;
					end else if (!inc_reg && wiper_code_o != `UDWSC_CODE_MIN) begin
						code_next = wiper_code_o - 6'h01;
					end
					state_next = ST_HIGH;
				end
			end
			ST_HIGH: begin
				if (phase_done) begin
					if (left_reg != 6'h00) begin
						step_next  = 1'b0;
						state_next = ST_LOW;
					end else begin
						// end level stands a full phase before release
						step_next  = end_reg;
						state_next = ST_END;
					end
				end
			end
			ST_END: begin
				if (phase_done) begin
					// release promptly so stray edges cannot move the wiper
					sel_low_n_next = 1'b1;
					sel_hv_next    = 1'b0;
					state_next     = ST_REL;
				end
			end
			ST_REL: begin
				if (phase_done) begin
					// zero-step commands park only after release, never racing select
					step_next  = end_reg;
					done_next  = 1'b1;
					ready_next = 1'b1;
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_reg    <= ST_IDLE;
			cnt_reg      <= 8'h00;
			left_reg     <= 6'h00;
			inc_reg      <= 1'b0;
			hv_reg       <= 1'b0;
			end_reg      <= 1'b0;
			cmd_ready_o  <= 1'b0;
			cmd_done_o   <= 1'b0;
			wiper_code_o <= `UDWSC_CODE_POR;
			sel_low_n_o  <= 1'b1;
			sel_hv_o     <= 1'b0;
			step_dir_o   <= 1'b0;
		end else begin
			state_reg    <= state_next;
			cnt_reg      <= cnt_next;
			left_reg     <= left_next;
			inc_reg      <= inc_next;
			hv_reg       <= hv_next;
			end_reg      <= end_next;
			cmd_ready_o  <= ready_next;
			cmd_done_o   <= done_next;
			wiper_code_o <= code_next;
			sel_low_n_o  <= sel_low_n_next;
			sel_hv_o     <= sel_hv_next;
			step_dir_o   <= step_next;
		end
	end

endmodule // udwsc_host

// ===== common/udwsc_defs.vh
`ifndef UDWSC_DEFS_VH
`define UDWSC_DEFS_VH

// wiper code range and power-on default
`define UDWSC_CODE_W      6
`define UDWSC_CODE_MAX    6'h3f
`define UDWSC_CODE_MIN    6'h00
`define UDWSC_CODE_POR    6'h1f

// command kinds on cmd_kind_i
`define UDWSC_KIND_W      3
`define UDWSC_K_INC       3'h0
`define UDWSC_K_INC_COMP  3'h1
`define UDWSC_K_DEC       3'h2
`define UDWSC_K_DEC_COMP  3'h3
`define UDWSC_K_HV_INC1   3'h4
`define UDWSC_K_HV_INC2   3'h5
`define UDWSC_K_HV_DEC1   3'h6
`define UDWSC_K_HV_DEC2   3'h7

// pin phase length in ns, and cycles at 250 MHz (rounded up, least times)
`define UDWSC_CLK_NS      4
`define UDWSC_PHASE_NS    40
`define UDWSC_PHASE_CYC   ((`UDWSC_PHASE_NS + `UDWSC_CLK_NS - 1) / `UDWSC_CLK_NS)
`define UDWSC_CNT_W       8

`endif

// ===== bench/udwsc_dev_model.sv
`timescale 1ns/10ps
`include "udwsc_defs.vh"
module udwsc_dev_model (
	// device pins
	input  wire       sel_low_n_i,
	input  wire       sel_hv_i,
	input  wire       step_dir_i,
	// supply recovery
	input  wire       recover_i,
	output reg  [5:0] code_o
);
	reg dir_up;
	initial code_o = `UDWSC_CODE_POR;
	always @(negedge sel_low_n_i or posedge sel_hv_i) dir_up = step_dir_i;
	always @(posedge step_dir_i)
		if (!sel_low_n_i || sel_hv_i)
			if (dir_up) code_o = code_o + (code_o != 6'h3f);
			else code_o = code_o - (code_o != 6'h00);
	always @(posedge recover_i) code_o = `UDWSC_CODE_POR;
endmodule // udwsc_dev_model

// ===== bench/udwsc_asserts.sv
`timescale 1ns/10ps
`include "udwsc_defs.vh"
module udwsc_asserts (
	input wire       clock_i,
	input wire       arst_n_i,
	input wire       cmd_valid_i,
	input wire [2:0] cmd_kind_i,
	input wire [5:0] cmd_steps_i,
	input wire       resync_i,
	input wire       cmd_ready_o,
	input wire       cmd_done_o,
	input wire       sel_low_n_o,
	input wire       sel_hv_o,
	input wire       step_dir_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);
	reg [2:0] kind_reg;
	reg       zero_reg;
	// zero-step commands hold the direction level, so end levels do not apply
	always @(posedge clock_i or negedge arst_n_i)
		if (!arst_n_i) begin
			kind_reg <= 3'h0;
			zero_reg <= 1'b1;
		end else if (cmd_valid_i && cmd_ready_o && !resync_i) begin
			kind_reg <= cmd_kind_i;
			zero_reg <= cmd_steps_i == 6'h00;
		end
	sequence hv_rel; !zero_reg ##0 $fell(sel_hv_o); endsequence
	sequence lo_rel; !zero_reg ##0 $rose(sel_low_n_o); endsequence
	chk_hv_end_level: assert property (hv_rel |->
		$past(step_dir_o) == (kind_reg == `UDWSC_K_HV_INC1 || kind_reg == `UDWSC_K_HV_DEC2))
		else $error("hv end level");
	chk_inc_comp_low: assert property (lo_rel ##0 kind_reg == `UDWSC_K_INC_COMP |->
		!$past(step_dir_o)) else $error("compat inc end level");
	chk_dec_comp_high: assert property (lo_rel ##0 kind_reg == `UDWSC_K_DEC_COMP |->
		$past(step_dir_o))
		else $error("compat dec end level");
	chk_done_ready: assert property (cmd_done_o |-> cmd_ready_o) else $error("not ready at done");
	chk_done_idle: assert property (cmd_done_o |-> sel_low_n_o && !sel_hv_o)
		else $error("select not idle at done");
endmodule // udwsc_asserts
bind udwsc_host udwsc_asserts udwsc_asserts_i (.clock_i(clock_i), .arst_n_i(arst_n_i),
	.cmd_valid_i(cmd_valid_i), .cmd_kind_i(cmd_kind_i), .cmd_steps_i(cmd_steps_i),
	.resync_i(resync_i), .cmd_ready_o(cmd_ready_o), .cmd_done_o(cmd_done_o),
	.sel_low_n_o(sel_low_n_o), .sel_hv_o(sel_hv_o), .step_dir_o(step_dir_o));

// ===== bench/tb.sv
`timescale 1ns/10ps
`include "udwsc_defs.vh"
module tb;
	reg        clock_i = 0, arst_n_i = 0, cmd_valid_i = 0, resync_i = 0;
	reg  [2:0] cmd_kind_i = 3'h0;
	reg  [5:0] cmd_steps_i = 6'h00;
	reg  [7:0] lfsr = 8'h3c;
	wire       cmd_ready_o, cmd_done_o, sel_low_n_o, sel_hv_o, step_dir_o;
	wire [5:0] wiper_code_o, dev_code;
	integer    failures = 0, checks = 0, exp = 31, want = 31, i, n;
	reg        hung = 1'b0;
	int        exp_q[$];
	always #2 clock_i = ~clock_i;
	function [7:0] lfsr_next(input [7:0] v);
		lfsr_next = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	udwsc_host udwsc_host_i (.clock_i(clock_i), .arst_n_i(arst_n_i), .cmd_valid_i(cmd_valid_i),
		.cmd_kind_i(cmd_kind_i), .cmd_steps_i(cmd_steps_i), .resync_i(resync_i),
		.cmd_ready_o(cmd_ready_o), .cmd_done_o(cmd_done_o), .wiper_code_o(wiper_code_o),
		.sel_low_n_o(sel_low_n_o), .sel_hv_o(sel_hv_o), .step_dir_o(step_dir_o));
	udwsc_dev_model udwsc_dev_model_i (.sel_low_n_i(sel_low_n_o), .sel_hv_i(sel_hv_o),
		.step_dir_i(step_dir_o), .recover_i(resync_i), .code_o(dev_code));
	task check(input [5:0] got); begin
		checks = checks + 1;
		if (got !== want[5:0]) begin
			failures = failures + 1;
			$display("[ERR] %0t code %h expected %h", $time, got, want[5:0]);
		end
	end endtask
	task complete_run; begin
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	end endtask
	// valid drops once taken; the next call raises it again after done
	task run(input [2:0] k, input [5:0] s); begin
		if (!hung) begin
			cmd_kind_i = k;
			cmd_steps_i = s;
			cmd_valid_i = 1'b1;
			for (n = 0; cmd_ready_o !== 1'b1 && n < 50; n = n + 1) @(posedge clock_i) #1;
			if (n >= 50) hung = 1'b1;
			@(posedge clock_i) #1 cmd_valid_i = 1'b0;
			for (n = 0; !hung && cmd_done_o !== 1'b1 && n < 2000; n = n + 1)
				@(posedge clock_i) #1;
			if (n >= 2000) hung = 1'b1;
			if (hung) begin
				failures = failures + 1;
				$display("[ERR] %0t command %0d hung", $time, k);
			end
			exp = k[1] ? (exp > s ? exp - s : 0) : (exp + s > 63 ? 63 : exp + s);
			exp_q.push_back(exp);
			want = exp_q.pop_front();
			check(wiper_code_o);
			check(dev_code);
		end
	end endtask
	initial begin
		repeat (20) @(posedge clock_i);
		#1 arst_n_i = 1'b1;
		run(`UDWSC_K_INC, 6'h3f);
		run(`UDWSC_K_HV_DEC1, 6'h3f);
		for (i = 0; i < 16; i = i + 1) begin
			lfsr = lfsr_next(lfsr);
			run(i[2:0], lfsr[5:0]);
		end
		resync_i = 1'b1;
		repeat (3) @(posedge clock_i);
		#1 resync_i = 1'b0;
		exp = 31;
		exp_q.push_back(exp);
		want = exp_q.pop_front();
		check(wiper_code_o);
		check(dev_code);
		complete_run;
	end
endmodule // tb
